// ### core/cx_divider.sv
// Purpose: iterative unsigned 32 by 32 divider, one quotient bit per clock
// Assumes: divisor is nonzero when start is raised
// Notes: sign handling lives in the caller
`timescale 1ns/100ps
module cx_divider import cx_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [31:0] divisor,
	// answer
	output logic done,
	output logic [31:0] quotient,
	output logic [31:0] remainder
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [31:0] quo;
		logic [31:0] rem;
		logic [31:0] dvs;
	} cx_div_s;

	cx_div_s q;
	cx_div_s d;
	logic [32:0] shifted;
	logic [32:0] trial;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.done = 1'b0;
		shifted = {q.rem, q.quo[31]};
		trial = shifted - {1'b0, q.dvs};
		if (start) begin
			d.busy = 1'b1;
			d.cnt = CX_DIV_STEPS;
			d.quo = dividend;
			d.rem = 32'h00000000;
			d.dvs = divisor;
		end else if (q.busy) begin
			// restoring step; the 33rd bit catches a shifted remainder above 32 bits
			if (!trial[32]) begin
				d.rem = trial[31:0];
				d.quo = {q.quo[30:0], 1'b1};
			end else begin
				d.rem = shifted[31:0];
				d.quo = {q.quo[30:0], 1'b0};
			end
			d.cnt = q.cnt - 6'h01;
			if (q.cnt == 6'h01) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign quotient = q.quo;
	assign remainder = q.rem;

endmodule // cx_divider

// ### core/cx_exec.sv
// Purpose: executes a decoded slice of the instruction set against registers, pc and status word
// Assumes: memory answers each request with one mem_ack pulse, same clock
// Notes: r0 reads as zero and ignores writes
`timescale 1ns/100ps
// Summary of operation
// - frame release adds short_immediate times four to sp, then pops listed registers
// - the returning frame release then jumps to the first source register
// - signed word divide: quotient to reg2, remainder to reg3, overflow sign zero updated
// - two-operand signed half divide writes quotient only, updates overflow, sign, zero
// - three-operand signed half divide writes quotient and remainder, updates flags
// - unsigned half divide by low halfword, quotient and remainder, flags updated
// - unsigned word divide, quotient and remainder, overflow sign zero updated
// - interrupt enable clears the disable flag, effective from the next instruction
// - halt stops the core clock and enters the halted state
// - halfword swap exchanges halves, sets carry sign zero, clears overflow
// - jump and link saves pc plus four then adds the displacement
// - displacement bit zero is forced low for both relative jumps
// - register jump goes to the register address with bit zero cleared
// - relative jump adds the displacement and saves no return address
// - signed byte load: base plus displacement, byte sign-extended
// - unsigned byte load: same address, byte zero-extended
// - signed half load clears address bit zero, sign-extends
// - unsigned half load clears address bit zero, zero-extends
// - word load clears address bits one and zero
// - system register write copies the word; status word takes flag bits
// - short immediate move sign-extends; register move copies; no flags touched
// - long immediate move writes the 32-bit immediate, no flags touched
// - effective address move adds sign-extended immediate, flags unchanged
module cx_exec import cx_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// decoded instruction
	input wire logic instr_valid,
	input wire cx_op_e instr_op,
	input wire logic [2:0] instr_len,
	input wire logic [4:0] reg1_sel,
	input wire logic [4:0] reg2_sel,
	input wire logic [4:0] reg3_sel,
	input wire logic [4:0] short_immediate,
	input wire logic [15:0] imm16,
	input wire logic [21:0] disp22,
	input wire logic [31:0] imm32,
	input wire logic [11:0] register_pop_list,
	input wire logic [4:0] system_register_selector,
	output logic instr_ready,
	output logic instr_done,
	// memory read port
	output logic mem_req,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// halt and wake
	input wire logic wake,
	output logic halted,
	output logic core_clk_run,
	// state visibility
	output logic [31:0] pc,
	output logic [31:0] status_word,
	output logic interrupt_enable_op_ok,
	input wire logic [4:0] debug_reg_sel,
	output logic [31:0] debug_reg
);

	typedef struct packed {
		cx_state_e st;
		logic [31:0][31:0] regs;
		logic [31:0][31:0] sysregs;
		logic [31:0] pc;
		logic [31:0] seq_pc;
		logic [31:0] jump_tgt;
		cx_op_e op;
		logic [4:0] r2;
		logic [4:0] r3;
		logic [11:0] pop_list;
		logic [3:0] pop_idx;
		logic [1:0] addr_lo;
		logic ready;
		logic done;
		logic mem_req;
		logic [31:0] mem_addr;
		logic [1:0] mem_size;
		logic div_start;
		logic [31:0] div_a;
		logic [31:0] div_b;
		logic neg_quo;
		logic neg_rem;
		logic div_ovf;
		logic halted;
		logic clk_run;
		logic int_ok;
		logic [31:0] debug_reg;
		logic wake_s1;
		logic wake_s2;
	} cx_core_s;

	cx_core_s q;
	cx_core_s d;
	logic div_done;
	logic [31:0] div_quo;
	logic [31:0] div_rem;
	logic [31:0] load_value;

	////////////////////////////////////////////////////////////////////////
	cx_divider u_div (
		.clk(clk),
		.rst(rst),
		.start(q.div_start),
		.dividend(q.div_a),
		.divisor(q.div_b),
		.done(div_done),
		.quotient(div_quo),
		.remainder(div_rem)
	);

	cx_load_align u_align (
		.word(mem_rdata),
		.addr_lo(q.addr_lo),
		.size(q.mem_size),
		.sign_ext(q.op == CX_OP_SIGNED_BYTE_LOAD || q.op == CX_OP_SIGNED_HALF_LOAD),
		.value(load_value)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rd(input cx_core_s s, input logic [4:0] idx);
		rd = (idx == 5'h00) ? 32'h00000000 : s.regs[idx];
	endfunction

	function automatic logic [31:0] magnitude(input logic [31:0] v, input logic neg);
		magnitude = neg ? (32'h00000000 - v) : v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] addr;
		logic [31:0] res;
		logic [31:0] quo;
		logic [31:0] rem;
		logic [31:0] disp;
		logic is_signed;
		a = 32'h00000000;
		b = 32'h00000000;
		addr = 32'h00000000;
		res = 32'h00000000;
		quo = 32'h00000000;
		rem = 32'h00000000;
		disp = 32'h00000000;
		is_signed = 1'b0;
		d = q;
		d.done = 1'b0;
		d.div_start = 1'b0;
		// only the second stage is looked at; the first just settles
		d.wake_s1 = wake;
		d.wake_s2 = q.wake_s1;
		unique case (q.st)
			CX_ST_IDLE: begin
				if (instr_valid) begin
					a = rd(q, reg1_sel);
					b = rd(q, reg2_sel);
					d.op = instr_op;
					d.r2 = reg2_sel;
					d.r3 = reg3_sel;
					d.seq_pc = q.pc + {29'h0, instr_len};
					d.pc = d.seq_pc;
					d.done = 1'b1;
					// conditions are held in the status word unless a branch below writes them
					disp = {{10{disp22[21]}}, disp22[21:1], 1'b0};
					addr = a + {{16{imm16[15]}}, imm16};
					unique case (instr_op)
						CX_OP_NOP: begin
						end
						CX_OP_FRAME_RELEASE, CX_OP_FRAME_RELEASE_RET: begin
							d.regs[CX_SP_INDEX] = rd(q, CX_SP_INDEX) +
								{25'h0, short_immediate, 2'h0};
							d.jump_tgt = a;
							d.pop_list = register_pop_list;
							d.pop_idx = 4'h0;
							d.done = 1'b0;
							d.st = CX_ST_POP;
						end
						CX_OP_SIGNED_WORD_DIVIDE, CX_OP_SIGNED_HALF_DIVIDE2, CX_OP_SIGNED_HALF_DIVIDE3,
						CX_OP_UNSIGNED_HALF_DIVIDE, CX_OP_UNSIGNED_WORD_DIVIDE: begin
							is_signed = (instr_op == CX_OP_SIGNED_WORD_DIVIDE) ||
								(instr_op == CX_OP_SIGNED_HALF_DIVIDE2) || (instr_op == CX_OP_SIGNED_HALF_DIVIDE3);
							if (instr_op == CX_OP_SIGNED_HALF_DIVIDE2 || instr_op == CX_OP_SIGNED_HALF_DIVIDE3) begin
								a = {{16{a[15]}}, a[15:0]};
							end else if (instr_op == CX_OP_UNSIGNED_HALF_DIVIDE) begin
								a = {16'h0000, a[15:0]};
							end
							d.neg_quo = is_signed & (a[31] ^ b[31]);
							d.neg_rem = is_signed & b[31];
							d.div_a = magnitude(b, is_signed & b[31]);
							d.div_b = magnitude(a, is_signed & a[31]);
							d.div_ovf = is_signed & (b == CX_MIN_WORD) & (a == CX_ALL_ONES);
							if (a == 32'h00000000) begin
								// divide by zero: registers kept, only overflow raised
								d.sysregs[CX_STATUS_SELECTOR][CX_OVERFLOW_BIT] = 1'b1;
							end else begin
								d.div_start = 1'b1;
								d.done = 1'b0;
								d.st = CX_ST_DIV_WAIT;
							end
						end
						CX_OP_INTERRUPT_ENABLE: begin
							d.sysregs[CX_STATUS_SELECTOR][CX_INT_DISABLE_BIT] = 1'b0;
						end
						CX_OP_HALT: begin
							d.halted = 1'b1;
							d.st = CX_ST_HALTED;
						end
						CX_OP_HALFWORD_SWAP: begin
							res = {b[15:0], b[31:16]};
							if (reg3_sel != 5'h00) begin
								d.regs[reg3_sel] = res;
							end
							d.sysregs[CX_STATUS_SELECTOR][CX_CARRY_BIT] = (res[15:0] == 16'h0000) ||
								(res[31:16] == 16'h0000);
							d.sysregs[CX_STATUS_SELECTOR][CX_OVERFLOW_BIT] = 1'b0;
							d.sysregs[CX_STATUS_SELECTOR][CX_SIGN_BIT] = res[31];
							d.sysregs[CX_STATUS_SELECTOR][CX_ZERO_BIT] = (res == 32'h00000000);
						end
						CX_OP_JUMP_AND_LINK: begin
							if (reg2_sel != 5'h00) begin
								d.regs[reg2_sel] = q.pc + CX_LINK_OFFSET;
							end
							d.pc = q.pc + disp;
						end
						CX_OP_REGISTER_JUMP: begin
							d.pc = {a[31:1], 1'b0};
						end
						CX_OP_RELATIVE_JUMP: begin
							d.pc = q.pc + disp;
						end
						CX_OP_SIGNED_BYTE_LOAD, CX_OP_UNSIGNED_BYTE_LOAD: begin
							d.mem_addr = addr;
							d.mem_size = CX_SIZE_BYTE;
						end
						CX_OP_SIGNED_HALF_LOAD, CX_OP_UNSIGNED_HALF_LOAD: begin
							d.mem_addr = {addr[31:1], 1'b0};
							d.mem_size = CX_SIZE_HALF;
						end
						CX_OP_WORD_LOAD: begin
							d.mem_addr = {addr[31:2], 2'h0};
							d.mem_size = CX_SIZE_WORD;
						end
						CX_OP_SYSTEM_REGISTER_WRITE: begin
							d.sysregs[system_register_selector] = (system_register_selector == CX_STATUS_SELECTOR) ?
								(b & CX_STATUS_MASK) : b;
						end
						CX_OP_REGISTER_MOVE: begin
							if (reg2_sel != 5'h00) begin
								d.regs[reg2_sel] = a;
							end
						end
						CX_OP_SHORT_IMM_MOVE: begin
							if (reg2_sel != 5'h00) begin
								d.regs[reg2_sel] = {{27{short_immediate[4]}}, short_immediate};
							end
						end
						CX_OP_LONG_IMM_MOVE: begin
							if (reg1_sel != 5'h00) begin
								d.regs[reg1_sel] = imm32;
							end
						end
						CX_OP_EFFECTIVE_ADDRESS_MOVE: begin
							if (reg2_sel != 5'h00) begin
								d.regs[reg2_sel] = addr;
							end
						end
					endcase
					if (instr_op == CX_OP_SIGNED_BYTE_LOAD || instr_op == CX_OP_UNSIGNED_BYTE_LOAD ||
						instr_op == CX_OP_SIGNED_HALF_LOAD || instr_op == CX_OP_UNSIGNED_HALF_LOAD ||
						instr_op == CX_OP_WORD_LOAD) begin
						d.addr_lo = d.mem_addr[1:0];
						d.mem_req = 1'b1;
						d.done = 1'b0;
						d.st = CX_ST_MEM_WAIT;
					end
				end
			end
			CX_ST_POP: begin
				if (q.pop_idx == CX_POP_COUNT) begin
					d.pc = (q.op == CX_OP_FRAME_RELEASE_RET) ? q.jump_tgt : q.seq_pc;
					d.done = 1'b1;
					d.st = CX_ST_IDLE;
				end else if (q.pop_list[q.pop_idx]) begin
					addr = rd(q, CX_SP_INDEX);
					d.mem_addr = {addr[31:2], 2'h0};
					d.mem_size = CX_SIZE_WORD;
					d.addr_lo = 2'h0;
					d.mem_req = 1'b1;
					d.st = CX_ST_MEM_WAIT;
				end else begin
					d.pop_idx = q.pop_idx + 4'h1;
				end
			end
			CX_ST_MEM_WAIT: begin
				if (mem_ack) begin
					d.mem_req = 1'b0;
					if (q.op == CX_OP_FRAME_RELEASE || q.op == CX_OP_FRAME_RELEASE_RET) begin
						d.regs[CX_POP_BASE + {1'b0, q.pop_idx}] = mem_rdata;
						d.regs[CX_SP_INDEX] = d.regs[CX_SP_INDEX] + CX_POP_STEP;
						d.pop_idx = q.pop_idx + 4'h1;
						d.st = CX_ST_POP;
					end else begin
						if (q.r2 != 5'h00) begin
							d.regs[q.r2] = load_value;
						end
						d.done = 1'b1;
						d.st = CX_ST_IDLE;
					end
				end
			end
			CX_ST_DIV_WAIT: begin
				if (div_done) begin
					quo = magnitude(div_quo, q.neg_quo);
					rem = magnitude(div_rem, q.neg_rem);
					if (q.r2 != 5'h00) begin
						d.regs[q.r2] = quo;
					end
					// remainder written last, so it wins when both selectors match
					if (q.op != CX_OP_SIGNED_HALF_DIVIDE2 && q.r3 != 5'h00) begin
						d.regs[q.r3] = rem;
					end
					d.sysregs[CX_STATUS_SELECTOR][CX_OVERFLOW_BIT] = q.div_ovf;
					d.sysregs[CX_STATUS_SELECTOR][CX_SIGN_BIT] = quo[31];
					d.sysregs[CX_STATUS_SELECTOR][CX_ZERO_BIT] = (quo == 32'h00000000);
					d.done = 1'b1;
					d.st = CX_ST_IDLE;
				end
			end
			CX_ST_HALTED: begin
				if (q.wake_s2) begin
					d.halted = 1'b0;
					d.st = CX_ST_IDLE;
				end
			end
		endcase
		d.ready = (d.st == CX_ST_IDLE);
		// ok rises at the retire edge, so the enabling instruction itself is never interrupted
		d.int_ok = ~d.sysregs[CX_STATUS_SELECTOR][CX_INT_DISABLE_BIT] & ~d.halted;
		d.clk_run = ~d.halted;
		d.debug_reg = rd(q, debug_reg_sel);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= CX_ST_IDLE;
			q.op <= CX_OP_NOP;
			q.pc <= CX_PC_RESET;
			q.sysregs[CX_STATUS_SELECTOR] <= CX_STATUS_RESET;
			q.ready <= 1'b1;
			q.clk_run <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign instr_ready = q.ready;
	assign instr_done = q.done;
	assign mem_req = q.mem_req;
	assign mem_addr = q.mem_addr;
	assign mem_size = q.mem_size;
	assign halted = q.halted;
	assign core_clk_run = q.clk_run;
	assign pc = q.pc;
	assign status_word = q.sysregs[CX_STATUS_SELECTOR];
	assign interrupt_enable_op_ok = q.int_ok;
	assign debug_reg = q.debug_reg;

endmodule // cx_exec

// ### core/cx_load_align.sv
// Purpose: pick a byte or halfword out of a fetched word and extend it
// Assumes: little-endian lanes, word holds the addressed location
// Notes: purely combinational; the caller registers the result
`timescale 1ns/100ps
module cx_load_align import cx_pkg::*; (
	// fetched data
	input wire logic [31:0] word,
	input wire logic [1:0] addr_lo,
	// access shape
	input wire logic [1:0] size,
	input wire logic sign_ext,
	// result
	output logic [31:0] value
);

	logic [31:0] lane;

	always_comb begin
		lane = word >> {addr_lo, 3'h0};
		value = lane;
		if (size == CX_SIZE_BYTE) begin
			value = {{24{sign_ext & lane[7]}}, lane[7:0]};
		end else if (size == CX_SIZE_HALF) begin
			value = {{16{sign_ext & lane[15]}}, lane[15:0]};
		end
	end

endmodule // cx_load_align

// ### core/cx_pkg.sv
// Purpose: shared constants and types for the instruction subset execution core
// Assumes: 32-bit words, 32 general registers, 32 system registers
// Notes: operations arrive already decoded; encodings are outside this block
package cx_pkg;

	// decoded operations
	typedef enum logic [4:0] {
		CX_OP_NOP,
		CX_OP_FRAME_RELEASE,
		CX_OP_FRAME_RELEASE_RET,
		CX_OP_SIGNED_WORD_DIVIDE,
		CX_OP_SIGNED_HALF_DIVIDE2,
		CX_OP_SIGNED_HALF_DIVIDE3,
		CX_OP_UNSIGNED_HALF_DIVIDE,
		CX_OP_UNSIGNED_WORD_DIVIDE,
		CX_OP_INTERRUPT_ENABLE,
		CX_OP_HALT,
		CX_OP_HALFWORD_SWAP,
		CX_OP_JUMP_AND_LINK,
		CX_OP_REGISTER_JUMP,
		CX_OP_RELATIVE_JUMP,
		CX_OP_SIGNED_BYTE_LOAD,
		CX_OP_UNSIGNED_BYTE_LOAD,
		CX_OP_SIGNED_HALF_LOAD,
		CX_OP_UNSIGNED_HALF_LOAD,
		CX_OP_WORD_LOAD,
		CX_OP_SYSTEM_REGISTER_WRITE,
		CX_OP_REGISTER_MOVE,
		CX_OP_SHORT_IMM_MOVE,
		CX_OP_LONG_IMM_MOVE,
		CX_OP_EFFECTIVE_ADDRESS_MOVE
	} cx_op_e;

	// core sequencing states
	typedef enum logic [2:0] {
		CX_ST_IDLE,
		CX_ST_POP,
		CX_ST_MEM_WAIT,
		CX_ST_DIV_WAIT,
		CX_ST_HALTED
	} cx_state_e;

	// memory access sizes
	localparam logic [1:0] CX_SIZE_BYTE = 2'h0;
	localparam logic [1:0] CX_SIZE_HALF = 2'h1;
	localparam logic [1:0] CX_SIZE_WORD = 2'h2;

	// status word layout
	localparam int CX_ZERO_BIT = 0;
	localparam int CX_SIGN_BIT = 1;
	localparam int CX_OVERFLOW_BIT = 2;
	localparam int CX_CARRY_BIT = 3;
	localparam int CX_SATURATION_BIT = 4;
	localparam int CX_INT_DISABLE_BIT = 5;
	localparam logic [31:0] CX_STATUS_MASK = 32'h0000003f;
	localparam logic [31:0] CX_STATUS_RESET = 32'h00000020;
	localparam logic [4:0] CX_STATUS_SELECTOR = 5'h05;

	// register file and stack
	localparam logic [4:0] CX_SP_INDEX = 5'h03;
	localparam logic [4:0] CX_POP_BASE = 5'h14;
	localparam logic [3:0] CX_POP_COUNT = 4'hc;
	localparam logic [31:0] CX_POP_STEP = 32'h00000004;
	localparam int CX_RELEASE_SHIFT = 2;
	localparam logic [31:0] CX_LINK_OFFSET = 32'h00000004;
	localparam logic [31:0] CX_PC_RESET = 32'h00000000;

	// divider
	localparam logic [5:0] CX_DIV_STEPS = 6'h20;
	localparam logic [31:0] CX_MIN_WORD = 32'h80000000;
	localparam logic [31:0] CX_ALL_ONES = 32'hffffffff;

endpackage

// ### tb/cx_exec_assertions.sv
// Purpose: concurrent checks on the execution core ports
// Assumes: one clock domain, async active high reset
// Notes: bound to cx_exec at the foot of this file
`timescale 1ns/100ps
module cx_exec_assertions import cx_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// instruction port
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic instr_done,
	input wire cx_op_e instr_op,
	input wire logic [21:0] disp22,
	// memory port
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	// state
	input wire logic halted,
	input wire logic core_clk_run,
	input wire logic [31:0] pc,
	input wire logic [31:0] status_word,
	input wire logic interrupt_enable_op_ok
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take;
	assign take = instr_valid && instr_ready;
////////////////////////////////////////////////////////////////////////////////
	half_align_a: assert property (mem_req && mem_size == CX_SIZE_HALF |-> !mem_addr[0])
		else $error("half access address odd");
	word_align_a: assert property (mem_req && mem_size == CX_SIZE_WORD |-> mem_addr[1:0] == 2'h0)
		else $error("word access address unaligned");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size))
		else $error("read request moved before answer");
	load_issue_a: assert property (take && instr_op inside {[CX_OP_SIGNED_BYTE_LOAD:CX_OP_WORD_LOAD]}
		|=> mem_req && !instr_ready) else $error("load did not issue a read");
	halt_entry_a: assert property (take && instr_op == CX_OP_HALT |=> halted && !core_clk_run && instr_done)
		else $error("halt did not stop the core clock");
	ie_clear_a: assert property (take && instr_op == CX_OP_INTERRUPT_ENABLE
		|=> !status_word[CX_INT_DISABLE_BIT] && interrupt_enable_op_ok) else $error("interrupt enable late");
	swap_flags_a: assert property (take && instr_op == CX_OP_HALFWORD_SWAP
		|=> instr_done && !status_word[CX_OVERFLOW_BIT]) else $error("swap left overflow set");
	move_flags_a: assert property (take && instr_op inside {[CX_OP_REGISTER_MOVE:CX_OP_EFFECTIVE_ADDRESS_MOVE]}
		|=> instr_done && $stable(status_word)) else $error("move changed the flags");
	rel_jump_a: assert property (take && instr_op == CX_OP_RELATIVE_JUMP |=> pc == $past(pc)
		+ {{10{$past(disp22[21])}}, $past(disp22[21:1]), 1'b0}) else $error("relative jump target wrong");
	reg_jump_a: assert property (take && instr_op == CX_OP_REGISTER_JUMP |=> !pc[0])
		else $error("register jump target odd");
endmodule // cx_exec_assertions
////////////////////////////////////////////////////////////////////////////////
bind cx_exec cx_exec_assertions u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
	.instr_done(instr_done), .instr_op(instr_op), .disp22(disp22), .mem_req(mem_req), .mem_ack(mem_ack),
	.mem_addr(mem_addr), .mem_size(mem_size), .halted(halted), .core_clk_run(core_clk_run), .pc(pc),
	.status_word(status_word), .interrupt_enable_op_ok(interrupt_enable_op_ok));

// ### tb/cx_exec_tb.sv
// Purpose: self-checking bench for the instruction subset execution core
// Assumes: partner memory answers after a delay set per test
// Notes: registers are loaded by moves and read back on the debug port
`timescale 1ns/100ps
module cx_exec_tb import cx_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0, wake = 1'b0, mem_ack, instr_ready, instr_done, mem_req, halted, core_clk_run, ie_ok;
	cx_op_e instr_op = CX_OP_NOP;
	logic [4:0] reg1_sel = 5'h0, reg2_sel = 5'h0, reg3_sel = 5'h0;
	logic [4:0] short_immediate = 5'h0, sys_sel = 5'h0, debug_reg_sel = 5'h0;
	logic [15:0] imm16 = 16'h0;
	logic [21:0] disp22 = 22'h0;
	logic [31:0] imm32 = 32'h0, mem_addr, mem_rdata, pc, status_word, debug_reg;
	logic [11:0] register_pop_list = 12'h0;
	logic [1:0] mem_size;
	logic [3:0] mem_dly = 4'h0;
	int failures = 0, comparisons = 0, cycles = 0;
////////////////////////////////////////////////////////////////////////////////
	cx_exec u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op), .instr_len(3'h4),
		.reg1_sel(reg1_sel), .reg2_sel(reg2_sel), .reg3_sel(reg3_sel), .short_immediate(short_immediate),
		.imm16(imm16), .disp22(disp22), .imm32(imm32), .register_pop_list(register_pop_list),
		.system_register_selector(sys_sel), .instr_ready(instr_ready), .instr_done(instr_done),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.wake(wake), .halted(halted), .core_clk_run(core_clk_run), .pc(pc), .status_word(status_word),
		.interrupt_enable_op_ok(ie_ok), .debug_reg_sel(debug_reg_sel), .debug_reg(debug_reg));
	cx_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .dly(mem_dly));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one value feeds every immediate field; each op picks what it uses
	task automatic run(input cx_op_e op, input logic [4:0] a, b, c, input logic [31:0] v);
		int n;
		n = 0;
		instr_op <= op;
		reg1_sel <= a;
		reg2_sel <= b;
		reg3_sel <= c;
		sys_sel <= c;
		imm32 <= v;
		imm16 <= v[15:0];
		disp22 <= v[21:0];
		short_immediate <= v[4:0];
		register_pop_list <= v[31:20];
		instr_valid <= 1'b1;
		do @(posedge clk); while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		do begin @(posedge clk); n++; end while (instr_done !== 1'b1 && n < 200);
		if (n >= 200) failures++;
	endtask
	task automatic rd(input logic [4:0] s, output logic [31:0] v);
		debug_reg_sel <= s;
		@(posedge clk);
		@(posedge clk);
		v = debug_reg;
	endtask
////////////////////////////////////////////////////////////////////////////////
	task automatic t_status;
		logic [31:0] v;
		run(CX_OP_LONG_IMM_MOVE, 5'h04, 0, 0, 32'hffffffe6);
		run(CX_OP_SYSTEM_REGISTER_WRITE, 0, 5'h04, CX_STATUS_SELECTOR, 0);
		chk(status_word, 32'h26);
		run(CX_OP_LONG_IMM_MOVE, 5'h04, 0, 0, 32'h12340000);
		run(CX_OP_HALFWORD_SWAP, 0, 5'h04, 5'h0c, 0);
		chk(status_word, 32'h28);
		rd(5'h0c, v);
		chk(v, 32'h00001234);
		run(CX_OP_INTERRUPT_ENABLE, 0, 0, 0, 0);
		chk(status_word, 32'h08);
		rd(5'h0, v);
		chk({31'h0, ie_ok}, 32'h1);
		$display("test status finished");
	endtask
	task automatic t_moves;
		logic [31:0] v;
		run(CX_OP_LONG_IMM_MOVE, 5'h08, 0, 0, 32'hdeadbeef);
		run(CX_OP_REGISTER_MOVE, 5'h08, 5'h09, 0, 0);
		rd(5'h09, v);
		chk(v, 32'hdeadbeef);
		run(CX_OP_SHORT_IMM_MOVE, 0, 5'h0a, 0, 32'h13);
		rd(5'h0a, v);
		chk(v, 32'hfffffff3);
		run(CX_OP_EFFECTIVE_ADDRESS_MOVE, 5'h08, 5'h0b, 0, 32'h8001);
		rd(5'h0b, v);
		chk(v, 32'hdeadbeef + 32'hffff8001);
		chk(status_word, 32'h08);
		$display("test moves finished");
	endtask
	task automatic t_divide;
		cx_op_e ops[5] = '{CX_OP_SIGNED_WORD_DIVIDE, CX_OP_SIGNED_HALF_DIVIDE2, CX_OP_SIGNED_HALF_DIVIDE3,
			CX_OP_UNSIGNED_HALF_DIVIDE, CX_OP_UNSIGNED_WORD_DIVIDE};
		logic [31:0] a, b, d, q, r, v;
		a = 32'h80000010;
		b = 32'hfffffffd;
		foreach (ops[i]) begin
			if (i < 3) begin
				q = $signed(a) / $signed(b);
				r = $signed(a) % $signed(b);
			end else begin
				d = (i == 3) ? {16'h0, b[15:0]} : b;
				q = a / d;
				r = a % d;
			end
			run(CX_OP_LONG_IMM_MOVE, 5'h05, 0, 0, a);
			run(CX_OP_LONG_IMM_MOVE, 5'h06, 0, 0, b);
			run(CX_OP_LONG_IMM_MOVE, 5'h07, 0, 0, 32'h11111111);
			run(ops[i], 5'h06, 5'h05, 5'h07, 0);
			chk(status_word, {26'h0, 4'h2, q[31], q == 32'h0});
			rd(5'h05, v);
			chk(v, q);
			rd(5'h07, v);
			chk(v, (i == 1) ? 32'h11111111 : r);
		end
		run(CX_OP_UNSIGNED_WORD_DIVIDE, 0, 5'h05, 5'h07, 0);
		chk(status_word, 32'h0d);
		$display("test divide finished");
	endtask
	task automatic t_jumps;
		logic [31:0] p, v;
		p = pc;
		run(CX_OP_JUMP_AND_LINK, 0, 5'h0d, 0, 32'h003ffff9);
		chk(pc, p + 32'hfffffff8);
		rd(5'h0d, v);
		chk(v, p + 32'h4);
		p = pc;
		run(CX_OP_RELATIVE_JUMP, 0, 5'h0d, 0, 32'h00000103);
		chk(pc, p + 32'h102);
		rd(5'h0d, p);
		chk(p, v);
		run(CX_OP_LONG_IMM_MOVE, 5'h0e, 0, 0, 32'h00004567);
		run(CX_OP_REGISTER_JUMP, 5'h0e, 0, 0, 0);
		chk(pc, 32'h00004566);
		$display("test jumps finished");
	endtask
	// base plus negative displacement lands on the odd address 0x9007
	task automatic t_loads;
		cx_op_e ops[5] = '{CX_OP_SIGNED_BYTE_LOAD, CX_OP_UNSIGNED_BYTE_LOAD, CX_OP_SIGNED_HALF_LOAD,
			CX_OP_UNSIGNED_HALF_LOAD, CX_OP_WORD_LOAD};
		logic [31:0] ex[5] = '{32'hffffffa5, 32'h000000a5, 32'hffffa5c3, 32'h0000a5c3, 32'ha5c306e5};
		logic [31:0] v;
		run(CX_OP_LONG_IMM_MOVE, 5'h0f, 0, 0, 32'h00010ffe);
		foreach (ops[i]) begin
			mem_dly <= 4'(i);
			run(ops[i], 5'h0f, 5'h10, 0, 32'h00008009);
			rd(5'h10, v);
			chk(v, ex[i]);
		end
		$display("test loads finished");
	endtask
	task automatic t_frame;
		logic [31:0] v;
		mem_dly <= 4'h3;
		run(CX_OP_LONG_IMM_MOVE, CX_SP_INDEX, 0, 0, 32'h00002000);
		run(CX_OP_LONG_IMM_MOVE, 5'h11, 0, 0, 32'h00003330);
		run(CX_OP_FRAME_RELEASE_RET, 5'h11, 0, 0, 32'h00500012);
		chk(pc, 32'h00003330);
		rd(5'h14, v);
		chk(v, 32'ha5c3b6a9);
		rd(5'h16, v);
		chk(v, 32'ha5c3b6ad);
		rd(CX_SP_INDEX, v);
		chk(v, 32'h00002050);
		run(CX_OP_FRAME_RELEASE, 5'h11, 0, 0, 32'h00000001);
		chk(pc, 32'h00003334);
		rd(CX_SP_INDEX, v);
		chk(v, 32'h00002054);
		$display("test frame release finished");
	endtask
	task automatic t_halt;
		int n;
		n = 0;
		run(CX_OP_HALT, 0, 0, 0, 0);
		chk({30'h0, halted, core_clk_run}, 32'h2);
		wake <= 1'b1;
		do begin @(posedge clk); n++; end while (halted !== 1'b0 && n < 20);
		wake <= 1'b0;
		chk({30'h0, halted, core_clk_run}, 32'h1);
		$display("test halt finished");
	endtask
////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_status();
		t_moves();
		t_divide();
		t_jumps();
		t_loads();
		t_frame();
		t_halt();
		end_of_test();
	end
endmodule // cx_exec_tb

// ### tb/cx_mem_model.sv
// Purpose: memory partner answering the core's reads
// Assumes: one read outstanding, ack after dly idle cycles
// Notes: data of a word is its aligned address folded with a constant
`timescale 1ns/100ps
module cx_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// read port
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// answer delay in cycles
	input wire logic [3:0] dly
);
	logic [3:0] cnt;
////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			cnt <= 4'h0;
		end else if (mem_req && !mem_ack && cnt >= dly) begin
			mem_ack <= 1'b1;
			mem_rdata <= {mem_addr[31:2], 2'h0} ^ 32'ha5c396e1; // whole word, core picks the lane
			cnt <= 4'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata; // idle data toggles so stale values never match
			cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule // cx_mem_model
